/* rtl/fbbp_host.sv */
// host controller that drives a parallel nor flash through bypass and buffered programming
//
// Summary of operation
// - bypass entry is two unlock writes then command 20h.
// - bypass exit writes 90h at any address, then 00h.
// - buffered start: two unlocks (dropped in bypass), load command at sector, then sector with count minus one.
// - page is address bits from A7 up of the first load; later loads stay inside.
// - after the counted loads, confirm is written at the sector address.
// - progress is polled at the last loaded address using the status bits.
// - after an abort, the abort reset sequence precedes any next operation.
// - abort reset in accelerated bypass uses the full three-cycle sequence.
// - sectors are unlocked before the accelerate pin is raised.
// - fail is followed by reset, abort by the abort reset command.
// - after a fail indication the toggle bit is read again, as a fresh pair of reads, before concluding.
module fbbp_host
    import fbbp_pkg::*;
#(
    parameter int AW   = ADDR_W,
    parameter int DW   = DQ_W,
    parameter int BUFN = BUF_WORDS
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          wbCyc,
    input  wire logic          wbStb,
    input  wire logic          wbWe,
    input  wire logic [3:0]    wbSel,
    input  wire logic [7:0]    wbAdr,
    input  wire logic [31:0]   wbDatW,
    output logic      [31:0]   wbDatR,
    output logic               wbAck,
    output logic      [AW-1:0] flashAddr,
    input  wire logic [DW-1:0] flashDqIn,
    output logic      [DW-1:0] flashDqOut,
    output logic               flashDqOe,
    output logic               flashCeN,
    output logic               flashWeN,
    output logic               flashOeN,
    output logic               accelHighReq
);
    // software registers
    logic [AW-1:0]        addrR;
    logic [DW-1:0]        dataR;
    logic                 accelEnR;
    logic                 unlockedR;
    logic                 busyR, doneR, abortR, failR, refusedR, bypassR;
    logic [DW-1:0]        rdDataR;
    logic [7:0]           loadPtrR;
    logic [PAGE_BITS+DW-1:0] bufMem [BUFN];

    // sequencer
    fbbp_state_t          stateR;
    logic [3:0]           curOpR;
    logic [7:0]           stepIdxR;
    logic [3:0]           cntR;
    logic                 pollCntR, recheckR;
    logic [DW-1:0]        prevR;
    logic [DW-1:0]        sampleR;

    logic                 wbWrite, wbRead, startReq, startOk, bypassEff;
    logic [3:0]           reqOp;
    logic [31:0]          statusWord;

    assign wbWrite   = wbCyc & wbStb & wbWe & ~wbAck;
    assign wbRead    = wbCyc & wbStb & ~wbWe & ~wbAck;
    assign reqOp     = wbDatW[CTRL_OP_LSB +: 4];
    assign startReq  = wbWrite & (wbAdr == REG_CTRL) & wbSel[0] & wbDatW[CTRL_START];
    assign bypassEff = bypassR | accelEnR;

    // operation admission: refuse sequences the flash would not honour in this mode
    always_comb begin
        startOk = ~busyR;
        unique case (reqOp)
            OP_BYP_ENTER:  startOk = startOk & ~bypassEff;
            OP_BYP_EXIT:   startOk = startOk & bypassR & ~accelEnR;
            OP_SECT_ERASE,
            OP_CHIP_ERASE: startOk = startOk & bypassEff;
            OP_BUF_PROG:   startOk = startOk & (loadPtrR != 8'h00) & (loadPtrR <= 8'(BUFN));
            OP_READ, OP_PROG, OP_ABORT_RST, OP_RESET: startOk = startOk;
            default:       startOk = 1'b0;
        endcase
    end

    // current step decode: what the sequencer issues for curOpR at stepIdxR
    fbbp_kind_t           stKind;
    logic [AW-1:0]        stAddr;
    logic [DW-1:0]        stData;
    logic [PAGE_BITS-1:0] bufIdx;
    logic [AW-1:0]        lastAddr;
    logic [7:0]           nLoads;

    assign nLoads   = loadPtrR;
    assign bufIdx   = PAGE_BITS'(stepIdxR - 8'h04);
    assign lastAddr = {addrR[AW-1:PAGE_BITS], bufMem[PAGE_BITS'(loadPtrR - 8'h01)][DW +: PAGE_BITS]};

    always_comb begin
        stKind = K_END;
        stAddr = addrR;
        stData = '0;
        // unlock pair shared by every full sequence
        if (stepIdxR == 8'h00) begin
            stAddr = UNLOCK_ADDR1;
            stData = UNLOCK_DATA1;
        end else begin
            stAddr = UNLOCK_ADDR2;
            stData = UNLOCK_DATA2;
        end
        unique case (curOpR)
            OP_READ: begin
                stAddr = addrR;
                stKind = (stepIdxR == 8'h00) ? K_READ : K_END;
            end
            OP_BYP_ENTER: begin
                if (stepIdxR < 8'h02) stKind = K_WRITE;
                else if (stepIdxR == 8'h02) begin
                    stKind = K_WRITE;
                    stAddr = UNLOCK_ADDR1;
                    stData = CMD_BYPASS;
                end
            end
            OP_BYP_EXIT: begin
                stAddr = addrR;
                if (stepIdxR < 8'h02) stKind = K_WRITE;
                stData = (stepIdxR == 8'h00) ? CMD_EXIT1 : CMD_EXIT2;
            end
            OP_ABORT_RST, OP_RESET: begin
                // always the full three cycles, also in accelerated bypass
                if (stepIdxR < 8'h03) stKind = K_WRITE;
                if (stepIdxR == 8'h02) begin
                    stAddr = UNLOCK_ADDR1;
                    stData = CMD_RESET;
                end
            end
            OP_PROG: begin
                if (stepIdxR < 8'h02) stKind = K_WRITE;
                else if (stepIdxR == 8'h02) begin
                    stKind = K_WRITE;
                    stAddr = UNLOCK_ADDR1;
                    stData = CMD_PROGRAM;
                end else if (stepIdxR == 8'h03) begin
                    stKind = K_WRITE;
                    stAddr = addrR;
                    stData = dataR;
                end else begin
                    stKind = K_POLL;
                    stAddr = addrR;
                end
            end
            OP_SECT_ERASE, OP_CHIP_ERASE: begin
                // bypass erase: set-up then erase command, two cycles only
                stAddr = addrR;
                if (stepIdxR == 8'h02) begin
                    stKind = K_WRITE;
                    stData = CMD_ERASE;
                end else if (stepIdxR == 8'h03) begin
                    stKind = K_WRITE;
                    stData = (curOpR == OP_SECT_ERASE) ? CMD_SECTOR : CMD_CHIP;
                end else begin
                    stKind = K_POLL;
                end
            end
            OP_BUF_PROG: begin
                if (stepIdxR < 8'h02) stKind = K_WRITE;
                else if (stepIdxR == 8'h02) begin
                    stKind = K_WRITE;
                    stAddr = addrR;
                    stData = CMD_BUFLOAD;
                end else if (stepIdxR == 8'h03) begin
                    stKind = K_WRITE;
                    stAddr = addrR;
                    stData = DW'(nLoads - 8'h01);
                end else if (stepIdxR < 8'h04 + nLoads) begin
                    // loads stay inside the page and sector of addrR
                    stKind = K_WRITE;
                    stAddr = {addrR[AW-1:PAGE_BITS], bufMem[bufIdx][DW +: PAGE_BITS]};
                    stData = bufMem[bufIdx][DW-1:0];
                end else if (stepIdxR == 8'h04 + nLoads) begin
                    stKind = K_WRITE;
                    stAddr = addrR;
                    stData = CMD_CONFIRM;
                end else begin
                    stKind = K_POLL;
                    stAddr = lastAddr;
                end
            end
            default: stKind = K_END;
        endcase
    end

    // wishbone answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wbAck  <= 1'b0;
            wbDatR <= 32'h00000000;
        end else if (ce) begin
            wbAck  <= wbCyc & wbStb & ~wbAck;
            wbDatR <= 32'h00000000;
            if (wbRead) begin
                unique case (wbAdr)
                    REG_CTRL:   wbDatR <= {22'h000000, unlockedR, accelEnR, 4'h0, curOpR};
                    REG_ADDR:   wbDatR <= 32'(addrR);
                    REG_DATA:   wbDatR <= 32'(dataR);
                    REG_STATUS: wbDatR <= statusWord;
                    REG_RDDATA: wbDatR <= 32'(rdDataR);
                    default:    wbDatR <= 32'h00000000; // unmapped reads zero
                endcase
            end
        end
    end

    always_comb begin
        statusWord = 32'h00000000;
        statusWord[ST_BUSY]    = busyR;
        statusWord[ST_BYPASS]  = bypassEff;
        statusWord[ST_DONE]    = doneR;
        statusWord[ST_ABORT]   = abortR;
        statusWord[ST_FAIL]    = failR;
        statusWord[ST_REFUSED] = refusedR;
        statusWord[ST_ACCEL]   = accelEnR;
        statusWord[ST_LOAD_LSB +: 8] = loadPtrR;
    end

    // byte lanes merged at full bus width, then cut on purpose to the register width
    logic [31:0]          addrMerge, dataMerge;
    always_comb begin
        addrMerge = 32'(addrR);
        dataMerge = 32'(dataR);
        for (int b = 0; b < 4; b++) begin
            if (wbSel[b]) begin
                addrMerge[b*8 +: 8] = wbDatW[b*8 +: 8];
                dataMerge[b*8 +: 8] = wbDatW[b*8 +: 8];
            end
        end
    end

    // address and data registers with byte lanes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            addrR <= '0;
            dataR <= '0;
        end else if (ce && wbWrite && !busyR) begin
            if (wbAdr == REG_ADDR) addrR <= addrMerge[AW-1:0];
            if (wbAdr == REG_DATA) dataR <= dataMerge[DW-1:0];
        end
    end

    // accelerate request: only raised once software vouches the sectors are unlocked
    always_ff @(posedge clock) begin
        if (!rstn) begin
            accelEnR     <= 1'b0;
            unlockedR    <= 1'b0;
            accelHighReq <= 1'b0;
        end else if (ce) begin
            if (wbWrite && wbAdr == REG_CTRL && wbSel[1] && !busyR) begin
                unlockedR <= wbDatW[CTRL_UNLOCKED];
                accelEnR  <= wbDatW[CTRL_ACCEL] & wbDatW[CTRL_UNLOCKED];
            end
            accelHighReq <= accelEnR;
        end
    end

    // buffer image: software appends offset/data pairs, a repeated offset still counts
    always_ff @(posedge clock) begin
        if (!rstn) begin
            loadPtrR <= 8'h00;
        end else if (ce) begin
            if (wbWrite && wbAdr == REG_CTRL && wbSel[0] && wbDatW[CTRL_BUFCLR] && !busyR)
                loadPtrR <= 8'h00;
            else if (wbWrite && wbAdr == REG_BUFWR && !busyR && loadPtrR < 8'(BUFN)) begin
                bufMem[PAGE_BITS'(loadPtrR)] <= {wbDatW[BUFWR_OFF_LSB +: PAGE_BITS], wbDatW[DW-1:0]};
                loadPtrR <= loadPtrR + 8'h01;
            end
        end
    end

    // refused flag: cleared when an operation is accepted, set when a start request is refused
    always_ff @(posedge clock) begin
        if (!rstn) begin
            refusedR <= 1'b0;
        end else if (ce && startReq) begin
            refusedR <= ~startOk;
        end
    end

    // sequencer and flash pins; no new operation is accepted while busy, which covers
    // the abort reset and the reset issued automatically after an abort or a fail
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stateR     <= S_IDLE;
            curOpR     <= OP_READ;
            stepIdxR   <= 8'h00;
            cntR       <= 4'h0;
            pollCntR   <= 1'b0;
            recheckR   <= 1'b0;
            prevR      <= '0;
            sampleR    <= '0;
            rdDataR    <= '0;
            busyR      <= 1'b0;
            doneR      <= 1'b0;
            abortR     <= 1'b0;
            failR      <= 1'b0;
            bypassR    <= 1'b0;
            flashAddr  <= '0;
            flashDqOut <= '0;
            flashDqOe  <= 1'b0;
            flashCeN   <= 1'b1;
            flashWeN   <= 1'b1;
            flashOeN   <= 1'b1;
        end else if (ce) begin
            if (!accelEnR && accelHighReq)
                bypassR <= 1'b0; // leaving accelerated mode also leaves bypass
            unique case (stateR)
                S_IDLE: begin
                    if (startReq && startOk) begin
                        busyR    <= 1'b1;
                        doneR    <= 1'b0;
                        abortR   <= 1'b0;
                        failR    <= 1'b0;
                        curOpR   <= reqOp;
                        recheckR <= 1'b0;
                        pollCntR <= 1'b0;
                        // bypass drops the unlock pair; resets always send all three cycles
                        stepIdxR <= (bypassEff && (reqOp == OP_PROG || reqOp == OP_BUF_PROG)) ? 8'h02 :
                                    ((reqOp == OP_SECT_ERASE || reqOp == OP_CHIP_ERASE) ? 8'h02 : 8'h00);
                        stateR   <= S_STEP;
                    end
                end
                S_STEP: begin
                    flashAddr <= stAddr;
                    if (stKind == K_WRITE) begin
                        flashDqOut <= stData;
                        flashDqOe  <= 1'b1;
                        flashCeN   <= 1'b0;
                        flashWeN   <= 1'b0;
                        cntR       <= WP_CYC;
                        stateR     <= S_WR;
                    end else if (stKind == K_END) begin
                        busyR  <= 1'b0;
                        doneR  <= 1'b1;
                        stateR <= S_IDLE;
                        if (curOpR == OP_BYP_ENTER) bypassR <= 1'b1;
                        if (curOpR == OP_BYP_EXIT) bypassR <= 1'b0;
                    end else begin
                        flashCeN <= 1'b0;
                        flashOeN <= 1'b0;
                        cntR     <= ACC_CYC;
                        stateR   <= S_RD;
                    end
                end
                S_WR: begin
                    if (cntR == 4'h1) begin
                        flashWeN <= 1'b1;
                        cntR     <= WPH_CYC;
                        stateR   <= S_WRGAP;
                    end else
                        cntR <= cntR - 4'h1;
                end
                S_WRGAP: begin
                    if (cntR == 4'h1) begin
                        flashDqOe <= 1'b0;
                        flashCeN  <= 1'b1;
                        stepIdxR  <= stepIdxR + 8'h01;
                        stateR    <= S_STEP;
                    end else
                        cntR <= cntR - 4'h1;
                end
                S_RD: begin
                    if (cntR == 4'h1) begin
                        sampleR  <= flashDqIn;
                        flashOeN <= 1'b1;
                        flashCeN <= 1'b1;
                        stateR   <= S_EVAL;
                    end else
                        cntR <= cntR - 4'h1;
                end
                S_EVAL: begin
                    if (stKind == K_READ) begin
                        rdDataR  <= sampleR;
                        stepIdxR <= stepIdxR + 8'h01;
                        stateR   <= S_STEP;
                    end else if (!pollCntR) begin
                        prevR    <= sampleR;
                        pollCntR <= 1'b1;
                        stateR   <= S_STEP;
                    end else if (prevR[TOGGLE_BIT] == sampleR[TOGGLE_BIT]) begin
                        // toggling stopped: the operation has ended
                        rdDataR  <= sampleR;
                        busyR    <= 1'b0;
                        doneR    <= 1'b1;
                        stateR   <= S_IDLE;
                    end else if (sampleR[ABORT_BIT] && !sampleR[FAIL_BIT]) begin
                        abortR   <= 1'b1;
                        rdDataR  <= sampleR;
                        curOpR   <= OP_ABORT_RST;
                        stepIdxR <= 8'h00;
                        stateR   <= S_STEP;
                    end else if (sampleR[FAIL_BIT] && recheckR) begin
                        failR    <= 1'b1;
                        rdDataR  <= sampleR;
                        curOpR   <= OP_RESET;
                        stepIdxR <= 8'h00;
                        stateR   <= S_STEP;
                    end else begin
                        // a fail seen once is confirmed by a fresh pair of reads
                        recheckR <= recheckR | sampleR[FAIL_BIT];
                        pollCntR <= ~sampleR[FAIL_BIT];
                        prevR    <= sampleR;
                        stateR   <= S_STEP;
                    end
                end
                default: stateR <= S_IDLE;
            endcase
        end
    end
endmodule

/* rtl/fbbp_pkg.sv */
// constants, register map and flash command codes for the flash bypass/buffer host controller
package fbbp_pkg;
    // flash word address and data widths (x16 mode)
    localparam int ADDR_W    = 22;
    localparam int DQ_W      = 16;
    localparam int PAGE_BITS = 7;                 // buffer page is address bits above bit 6
    localparam int BUF_WORDS = 128;               // buffer capacity in words

    // timing, figures in ns, counts derived from the 50 MHz clock
    localparam int CLK_NS    = 20;
    localparam int T_WP_NS   = 35;                // write strobe low time
    localparam int T_WPH_NS  = 20;                // write strobe high time
    localparam int T_ACC_NS  = 70;                // read access time
    localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_BUFWR  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDDATA = 8'h14;

    // control field positions
    localparam int CTRL_OP_LSB    = 0;            // op code, 4 bits
    localparam int CTRL_START     = 4;
    localparam int CTRL_BUFCLR    = 5;
    localparam int CTRL_ACCEL     = 8;
    localparam int CTRL_UNLOCKED  = 9;
    localparam int BUFWR_OFF_LSB  = 16;           // page offset, 7 bits

    // status field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_BYPASS  = 1;
    localparam int ST_DONE    = 2;
    localparam int ST_ABORT   = 3;
    localparam int ST_FAIL    = 4;
    localparam int ST_REFUSED = 5;
    localparam int ST_ACCEL   = 6;
    localparam int ST_LOAD_LSB = 8;               // load count, 8 bits

    // operations that software may start
    localparam logic [3:0] OP_READ        = 4'h0;
    localparam logic [3:0] OP_BYP_ENTER   = 4'h1;
    localparam logic [3:0] OP_BYP_EXIT    = 4'h2;
    localparam logic [3:0] OP_PROG        = 4'h3;
    localparam logic [3:0] OP_BUF_PROG    = 4'h4;
    localparam logic [3:0] OP_ABORT_RST   = 4'h5;
    localparam logic [3:0] OP_RESET       = 4'h6;
    localparam logic [3:0] OP_SECT_ERASE  = 4'h7;
    localparam logic [3:0] OP_CHIP_ERASE  = 4'h8;

    // flash command cycles
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h0002aa;
    localparam logic [DQ_W-1:0]   UNLOCK_DATA1 = 16'h00aa;
    localparam logic [DQ_W-1:0]   UNLOCK_DATA2 = 16'h0055;
    localparam logic [DQ_W-1:0]   CMD_BYPASS   = 16'h0020;
    localparam logic [DQ_W-1:0]   CMD_EXIT1    = 16'h0090;
    localparam logic [DQ_W-1:0]   CMD_EXIT2    = 16'h0000;
    localparam logic [DQ_W-1:0]   CMD_BUFLOAD  = 16'h0025;
    localparam logic [DQ_W-1:0]   CMD_CONFIRM  = 16'h0029;
    localparam logic [DQ_W-1:0]   CMD_PROGRAM  = 16'h00a0;
    localparam logic [DQ_W-1:0]   CMD_RESET    = 16'h00f0;
    localparam logic [DQ_W-1:0]   CMD_ERASE    = 16'h0080;
    localparam logic [DQ_W-1:0]   CMD_SECTOR   = 16'h0030;
    localparam logic [DQ_W-1:0]   CMD_CHIP     = 16'h0010;

    // status bits on the data lines
    localparam int POLARITY_BIT = 7;
    localparam int TOGGLE_BIT   = 6;
    localparam int FAIL_BIT     = 5;
    localparam int ABORT_BIT    = 1;

    // kinds of sequencer step and states of the sequencer
    typedef enum logic [1:0] {K_WRITE, K_READ, K_POLL, K_END} fbbp_kind_t;
    typedef enum logic [2:0] {S_IDLE, S_STEP, S_WR, S_WRGAP, S_RD, S_EVAL} fbbp_state_t;
endpackage

/* test/fbbp_flash_model.sv */
// behavioural nor flash answering the host controller
module fbbp_flash_model (
    input wire logic [21:0] addr,
    input wire logic [15:0] dq,
    input wire logic        weN,
    input wire logic        oeN,
    input wire logic        accel,
    output logic     [15:0] dqIn
);
    timeunit 1ns / 1ns;
    logic [15:0] mem [int], pend [int];
    logic [15:0] rd = 16'h0, last = 16'h0;
    logic [21:0] sec = 22'h0;
    logic byp = 0, abt = 0, forceAbt = 0;
    int st = 0, left = 0;
    // command decoder; while aborted only unlocked sequences are heard, and of their commands only reset and bypass entry act
    always @(posedge weN) begin
        if (st < 4) sec = addr;
        case (st)
        0: st = dq == 16'h00aa ? 1 : abt ? 0 : (byp || accel) && dq == 16'h0025 ? 3 : byp && dq == 16'h0090 ? 6 : 0;
        1: st = dq == 16'h0055 ? 2 : 0;
        2: begin byp |= dq == 16'h0020; abt &= dq != 16'h00f0; st = !abt && dq == 16'h0025 ? 3 : 0; end
        3: begin pend.delete(); left = dq + 1; abt = dq > 16'h007f; st = abt ? 0 : 4; end
        4: begin
            pend[addr] = dq; // a reloaded location keeps only its last value
            last = dq;
            left--;
            abt = addr[21:7] != sec[21:7];
            st = abt ? 0 : left > 0 ? 4 : 5;
        end
        5: begin abt = forceAbt || dq != 16'h0029 || addr[21:15] != sec[21:15]; st = 0;
            // the array only clears bits, whatever the buffer asks for
            if (!abt) foreach (pend[a]) mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & pend[a];
        end
        default: begin byp &= dq != 16'h0000; st = 0; end
        endcase
    end
    // a poll while aborted gives inverted polarity and a toggling bit 6
    always @(negedge oeN) rd = abt ? {8'h00, ~last[7], ~rd[6], 6'h02} : mem.exists(addr) ? mem[addr] : 16'hffff;
    assign dqIn = oeN ? ~rd : rd; // released lines do not keep the last word
endmodule

/* test/fbbp_host_bench.sv */
// self-checking bench for the flash host controller
module fbbp_host_bench
    import fbbp_pkg::*;
;
    timeunit 1ns / 1ns;
    logic clock = 0, rstn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, flashDqOe, flashCeN, flashWeN, flashOeN, accelReq;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    logic [21:0] flashAddr;
    logic [15:0] flashDqIn, flashDqOut;
    int err_total = 0, compares = 0;
    always #10 clock = ~clock;
    fbbp_host dut_u (.clock(clock), .rstn(rstn), .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(4'hf),
        .wbAdr(wbAdr), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .flashAddr(flashAddr), .flashDqIn(flashDqIn),
        .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashWeN(flashWeN),
        .flashOeN(flashOeN), .accelHighReq(accelReq));
    fbbp_flash_model fm_u (.addr(flashAddr), .dq(flashDqOut), .weN(flashWeN), .oeN(flashOeN), .accel(accelReq),
        .dqIn(flashDqIn));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin err_total++; $display("MISMATCH %s expected %h seen %h", what, exp, seen); end
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled, then one idle cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        wbCyc <= 1; wbStb <= 1; wbWe <= w; wbAdr <= a; wbDatW <= d;
        do begin @(posedge clock); n++; end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        wbCyc <= 0; wbStb <= 0;
        @(posedge clock);
        if (n >= 20) begin err_total++; conclude(); end
    endtask
    // start an op with control bits c, poll until idle, leave status in rd
    task automatic op(input logic [31:0] c);
        int n = 0;
        bus(REG_CTRL, 1, c | 32'h10);
        do begin bus(REG_STATUS, 0, 0); n++; end while (rd[ST_BUSY] !== 1'b0 && n < 300);
        if (n >= 300) begin err_total++; conclude(); end
    endtask
    task automatic t_refuse;
        logic [3:0] ops [5] = '{OP_SECT_ERASE, OP_CHIP_ERASE, OP_BYP_EXIT, 4'hf, OP_BUF_PROG};
        bus(REG_CTRL, 1, 32'h20);
        foreach (ops[i]) begin op(ops[i]); chk("refused", rd[ST_REFUSED], 1); end
    endtask
    task automatic t_bypass;
        op(OP_BYP_ENTER);
        chk("bypass", {rd[ST_BYPASS], fm_u.byp}, 2'b11);
        op(OP_BYP_ENTER);
        chk("reentry", rd[ST_REFUSED], 1);
        op(OP_BYP_EXIT);
        chk("exit", {rd[ST_BYPASS], fm_u.byp}, 0);
    endtask
    // three loads, one offset twice; bad makes the flash abort at confirm
    task automatic t_buffer(input logic bad, input logic [31:0] base);
        fm_u.forceAbt = bad;
        bus(REG_CTRL, 1, base | 32'h20);
        bus(REG_ADDR, 1, 32'h0012345);
        bus(REG_BUFWR, 1, 32'h0005_1111);
        bus(REG_BUFWR, 1, 32'h0005_2222);
        bus(REG_BUFWR, 1, 32'h0006_3333);
        op(base | OP_BUF_PROG);
        chk("abort", {rd[ST_ABORT], rd[ST_DONE]}, {bad, 1'b1});
        chk("flash abort", {fm_u.abt, 31'(fm_u.left)}, 0);
        chk("word", fm_u.mem[22'h12305], 16'h2222);
    endtask
    task automatic t_accel;
        bus(REG_CTRL, 1, 32'h100);
        chk("accel locked", accelReq, 0);
        op(32'h300 | OP_BYP_EXIT);
        chk("accel", {accelReq, rd[ST_BYPASS], rd[ST_REFUSED]}, 3'b111);
        t_buffer(1, 32'h300);
        bus(REG_CTRL, 1, 32'h200);
        chk("accel off", accelReq, 0);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        bus(REG_STATUS, 0, 0);
        chk("status", rd[6:0], 0);
        bus(8'hfc, 0, 0);
        chk("unmapped", rd, 0);
        t_refuse;
        t_bypass;
        op(OP_BYP_ENTER);
        t_buffer(0, 0);
        t_buffer(1, 0);
        op(OP_BYP_EXIT);
        t_accel;
        conclude;
    end
endmodule

/* test/fbbp_host_props.sv */
// port assertions for the flash host controller
module fbbp_host_props (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbAck,
    input wire logic [31:0] wbDatR,
    input wire logic [15:0] flashDqOut,
    input wire logic        flashDqOe,
    input wire logic        flashCeN,
    input wire logic        flashWeN,
    input wire logic        flashOeN
);
    timeunit 1ns / 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack too long");
    a_ack_answer: assert property (wbCyc && wbStb && !wbAck && ce |=> wbAck) else $error("no ack");
    a_rdata_quiet: assert property (!wbAck |-> wbDatR == 32'h0) else $error("stray data");
    a_write_strobe: assert property ($fell(flashWeN) |-> !flashCeN && flashDqOe ##1 !flashWeN ##1 flashWeN)
        else $error("bad strobe");
    a_write_hold: assert property (!flashWeN && $past(!flashWeN) |-> $stable(flashDqOut)) else $error("moved");
    a_read_len: assert property ($fell(flashOeN) |-> !flashCeN ##1 !flashOeN [*3]) else $error("short read");
    a_read_quiet: assert property (!flashOeN |-> !flashDqOe && flashWeN) else $error("drive in read");
    a_exit_pair: assert property ($fell(flashWeN) && flashDqOut == 16'h0090 |->
        ##[3:12] $fell(flashWeN) && flashDqOut == 16'h0000) else $error("lone exit");
    c_exit: cover property ($fell(flashWeN) && flashDqOut == 16'h0090);
    c_confirm: cover property ($fell(flashWeN) && flashDqOut == 16'h0029);
    c_reset: cover property ($fell(flashWeN) && flashDqOut == 16'h00f0);
endmodule
bind fbbp_host fbbp_host_props props_u (.clock(clock), .rstn(rstn), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbAck(wbAck), .wbDatR(wbDatR), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN),
    .flashWeN(flashWeN), .flashOeN(flashOeN));
